// ==== design/ivm_pkg.sv ====
package ivm_pkg;
   // table geometry
   localparam int IVM_NUM_SRC = 30;
   localparam int IVM_SRC_W = 5;
   localparam int IVM_ADDR_W = 16;
   localparam logic [15:0] IVM_RESET_ADDR = 16'h0000;
   localparam logic [15:0] IVM_TABLE_OFS = 16'h0002;
   // boot-reset fuse encoding: zero means programmed
   localparam logic IVM_FUSE_PROGRAMMED = 1'b0;
   // zero-based source indices, vector number minus two
   localparam logic [4:0] IVM_SRC_EXT_IRQ_0 = 5'h00;
   localparam logic [4:0] IVM_SRC_EXT_IRQ_2 = 5'h02;
   localparam logic [4:0] IVM_SRC_PIN_CHANGE_IRQ_0 = 5'h03;
   localparam logic [4:0] IVM_SRC_PIN_CHANGE_IRQ_3 = 5'h06;
   localparam logic [4:0] IVM_SRC_WATCHDOG = 5'h07;
   localparam logic [4:0] IVM_SRC_TIMER_B_OVF = 5'h0a;
   localparam logic [4:0] IVM_SRC_WIDE_TIMER_CAPTURE = 5'h0b;
   localparam logic [4:0] IVM_SRC_TIMER_A_OVF = 5'h11;
   localparam logic [4:0] IVM_SRC_SERIAL_PERIPH_DONE = 5'h12;
   localparam logic [4:0] IVM_SRC_PROGRAM_STORE_READY = 5'h1a;
   localparam logic [4:0] IVM_SRC_UART_B_TX_DONE = 5'h1d;
   // fixed vector addresses used by the checks
   localparam logic [15:0] IVM_VEC_EXT_IRQ_2 = 16'h0006;
   localparam logic [15:0] IVM_VEC_PIN_CHANGE_IRQ_3 = 16'h000e;
   localparam logic [15:0] IVM_VEC_WATCHDOG = 16'h0010;
   localparam logic [15:0] IVM_VEC_TIMER_B_OVF = 16'h0016;
   localparam logic [15:0] IVM_VEC_WIDE_TIMER_CAPTURE = 16'h0018;
   localparam logic [15:0] IVM_VEC_TIMER_A_OVF = 16'h0024;
   localparam logic [15:0] IVM_VEC_SERIAL_PERIPH_DONE = 16'h0026;
   localparam logic [15:0] IVM_VEC_PROGRAM_STORE_READY = 16'h0036;
   localparam logic [15:0] IVM_VEC_UART_B_TX_DONE = 16'h003c;

   // dispatcher states
   typedef enum logic [1:0] {
      IVM_ST_BOOT = 2'b00,
      IVM_ST_IDLE = 2'b01,
      IVM_ST_OFFER = 2'b10
   } ivm_state_type;
endpackage

// ==== design/ivm_vector_mapper.sv ====
`timescale 1ns/1ns
// Behaviour
// RQ1 - any reset starts fetch at the reset vector, zero unless relocated
// RQ2 - external requests 0, 1, 2 go to 0x0002, 0x0004, 0x0006
// RQ3 - pin-change requests 0 to 3 go to 0x0008 through 0x000E
// RQ4 - watchdog time-out request goes to 0x0010
// RQ5 - timer B compare A, compare B, overflow go to 0x0012..0x0016
// RQ6 - wide timer capture, compare A, B, overflow go to 0x0018..0x001E
// RQ7 - timer A compare A, compare B, overflow go to 0x0020..0x0024
// RQ8 - serial done to 0x0026, uart A receive, empty, transmit 0x0028..0x002C
// RQ9 - comparator, converter, nv data, two-wire, program store 0x002E..0x0036
// RQ10 - uart B receive, empty, transmit go to 0x0038..0x003C, table end
// RQ11 - programmed fuse moves reset start to the boot loader reset address
// RQ12 - table select set adds boot section start to every vector address
// RQ13 - table starts at boot address plus 0x0002 when selected, else 0x0002
// RQ14 - reset address and table base are chosen independently
// RQ15 - fuse value one is unprogrammed, zero is programmed
// RQ16 - taking watchdog vector clears its flag, and enable in combined mode
// RQ17 - among pending requests the lowest vector number wins
// RQ18 - each vector is two words: base plus twice the source index
module ivm_vector_mapper
   import ivm_pkg::*;
#(
   parameter int ADDR_W = IVM_ADDR_W,
   parameter int NUM_SRC = IVM_NUM_SRC
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // configuration
   input wire logic boot_reset_select_fuse_i,
   input wire logic vector_table_select_i,
   input wire logic [ADDR_W-1:0] boot_reset_addr_i,
   input wire logic watchdog_reset_mode_i,
   // peripheral requests, already masked by their own enables
   input wire logic [NUM_SRC-1:0] irq_pending_i,
   input wire logic irq_global_en_i,
   // core fetch side
   input wire logic core_take_i,
   output logic vector_valid_o,
   output logic vector_is_reset_o,
   output logic [ADDR_W-1:0] vector_addr_o,
   output logic [IVM_SRC_W-1:0] vector_src_o,
   output logic [NUM_SRC-1:0] irq_ack_o,
   output logic watchdog_irq_flag_clr_o,
   output logic watchdog_irq_enable_clr_o
);

   ivm_state_type state_q, state_d;
   logic valid_q, valid_d;
   logic is_reset_q, is_reset_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [IVM_SRC_W-1:0] src_q, src_d;
   logic tsel_q, tsel_d;
   logic [NUM_SRC-1:0] ack_q, ack_d;
   logic wdf_clr_q, wdf_clr_d;
   logic wde_clr_q, wde_clr_d;
   logic any_pend;
   logic [IVM_SRC_W-1:0] win_src;
   logic [ADDR_W-1:0] tbl_base;

   // priority pick: scanning downward leaves the lowest index standing
   always_comb begin
      any_pend = 1'b0;
      win_src = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (irq_pending_i[i]) begin
            any_pend = 1'b1;
            win_src = IVM_SRC_W'(i); // [RQ17]
         end
      end
   end

   // table base follows the select bit only, never the fuse
   always_comb begin
      if (vector_table_select_i) begin
         tbl_base = boot_reset_addr_i + ADDR_W'(IVM_TABLE_OFS); // [RQ12] [RQ13]
      end else begin
         tbl_base = ADDR_W'(IVM_TABLE_OFS); // [RQ13] [RQ14]
      end
   end

   // dispatcher next state
   always_comb begin
      state_d = state_q;
      valid_d = valid_q;
      is_reset_d = is_reset_q;
      addr_d = addr_q;
      src_d = src_q;
      tsel_d = tsel_q;
      ack_d = '0;
      wdf_clr_d = 1'b0;
      wde_clr_d = 1'b0;
      case (state_q)
         IVM_ST_BOOT: begin
            // fuse is read here, after release, not under reset
            valid_d = 1'b1;
            is_reset_d = 1'b1;
            if (boot_reset_select_fuse_i == IVM_FUSE_PROGRAMMED) begin
               addr_d = boot_reset_addr_i; // [RQ11] [RQ15]
            end else begin
               addr_d = ADDR_W'(IVM_RESET_ADDR); // [RQ1] [RQ14]
            end
            state_d = IVM_ST_OFFER;
         end
         IVM_ST_IDLE: begin
            if (irq_global_en_i && any_pend) begin
               valid_d = 1'b1;
               is_reset_d = 1'b0;
               src_d = win_src;
               tsel_d = vector_table_select_i;
               // two words per entry [RQ18] [RQ2] [RQ3] [RQ4] [RQ5]
               addr_d = tbl_base + ADDR_W'({win_src, 1'b0}); // [RQ6] [RQ7]
               state_d = IVM_ST_OFFER; // [RQ8] [RQ9] [RQ10]
            end
         end
         IVM_ST_OFFER: begin
            // the address stands until the core takes it
            if (core_take_i) begin
               valid_d = 1'b0;
               state_d = IVM_ST_IDLE;
               if (!is_reset_q) begin
                  ack_d[src_q] = 1'b1;
                  if (src_q == IVM_SRC_WATCHDOG) begin
                     wdf_clr_d = 1'b1; // [RQ16]
                     wde_clr_d = watchdog_reset_mode_i; // [RQ16]
                  end
               end
            end
         end
         default: begin
            state_d = IVM_ST_BOOT;
            valid_d = 1'b0;
         end
      endcase
   end

   // registers; clock enable low freezes everything
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= IVM_ST_BOOT;
         valid_q <= 1'b0;
         is_reset_q <= 1'b0;
         addr_q <= '0;
         src_q <= '0;
         tsel_q <= 1'b0;
         ack_q <= '0;
         wdf_clr_q <= 1'b0;
         wde_clr_q <= 1'b0;
      end else if (clk_en_i) begin
         state_q <= state_d;
         valid_q <= valid_d;
         is_reset_q <= is_reset_d;
         addr_q <= addr_d;
         src_q <= src_d;
         tsel_q <= tsel_d;
         ack_q <= ack_d;
         wdf_clr_q <= wdf_clr_d;
         wde_clr_q <= wde_clr_d;
      end
   end

   // outputs straight from flops
   assign vector_valid_o = valid_q;
   assign vector_is_reset_o = is_reset_q;
   assign vector_addr_o = addr_q;
   assign vector_src_o = src_q;
   assign irq_ack_o = ack_q;
   assign watchdog_irq_flag_clr_o = wdf_clr_q;
   assign watchdog_irq_enable_clr_o = wde_clr_q;

   // checks on reset and table vectors; fixed-address ones under default placement only
   logic irq_shown;
   assign irq_shown = valid_q && !is_reset_q && !tsel_q;

   property p_reset_vec;
      @(posedge clock_i) disable iff (!reset_n_i)
      (reset_n_i && state_q == IVM_ST_BOOT && clk_en_i
       && boot_reset_select_fuse_i) // release edge itself still resets
      |=> (valid_q && is_reset_q && addr_q == ADDR_W'(IVM_RESET_ADDR));
   endproperty
   a_reset_vec: assert property (p_reset_vec) // [RQ1]
      else $error("reset vector not at zero with fuse unprogrammed");
   property p_boot_vec;
      @(posedge clock_i) disable iff (!reset_n_i)
      (reset_n_i && state_q == IVM_ST_BOOT && clk_en_i
       && !boot_reset_select_fuse_i)
      |=> (valid_q && is_reset_q && addr_q == $past(boot_reset_addr_i));
   endproperty
   a_boot_vec: assert property (p_boot_vec) // [RQ11]
      else $error("programmed fuse did not relocate reset vector");

   property p_ext2;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_EXT_IRQ_2)
      |-> addr_q == ADDR_W'(IVM_VEC_EXT_IRQ_2);
   endproperty
   a_ext2: assert property (p_ext2) // [RQ2]
      else $error("external request 2 vector wrong");
   property p_pc3;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_PIN_CHANGE_IRQ_3)
      |-> addr_q == ADDR_W'(IVM_VEC_PIN_CHANGE_IRQ_3);
   endproperty
   a_pc3: assert property (p_pc3) // [RQ3]
      else $error("pin-change 3 vector wrong");
   property p_wdog;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_WATCHDOG)
      |-> addr_q == ADDR_W'(IVM_VEC_WATCHDOG);
   endproperty
   a_wdog: assert property (p_wdog) // [RQ4]
      else $error("watchdog vector wrong");
   property p_tmb;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_TIMER_B_OVF)
      |-> addr_q == ADDR_W'(IVM_VEC_TIMER_B_OVF);
   endproperty
   a_tmb: assert property (p_tmb) // [RQ5]
      else $error("timer B overflow vector wrong");
   property p_wide;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_WIDE_TIMER_CAPTURE)
      |-> addr_q == ADDR_W'(IVM_VEC_WIDE_TIMER_CAPTURE);
   endproperty
   a_wide: assert property (p_wide) // [RQ6]
      else $error("wide timer capture vector wrong");
   property p_tma;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_TIMER_A_OVF)
      |-> addr_q == ADDR_W'(IVM_VEC_TIMER_A_OVF);
   endproperty
   a_tma: assert property (p_tma) // [RQ7]
      else $error("timer A overflow vector wrong");
   property p_spd;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_SERIAL_PERIPH_DONE)
      |-> addr_q == ADDR_W'(IVM_VEC_SERIAL_PERIPH_DONE);
   endproperty
   a_spd: assert property (p_spd) // [RQ8]
      else $error("serial done vector wrong");
   property p_psr;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_PROGRAM_STORE_READY)
      |-> addr_q == ADDR_W'(IVM_VEC_PROGRAM_STORE_READY);
   endproperty
   a_psr: assert property (p_psr) // [RQ9]
      else $error("program store ready vector wrong");

   property p_ubt;
      @(posedge clock_i) disable iff (!reset_n_i)
      (irq_shown && src_q == IVM_SRC_UART_B_TX_DONE)
      |-> addr_q == ADDR_W'(IVM_VEC_UART_B_TX_DONE);
   endproperty
   a_ubt: assert property (p_ubt) // [RQ10]
      else $error("uart B transmit vector wrong");

   property p_moved;
      @(posedge clock_i) disable iff (!reset_n_i)
      (state_q == IVM_ST_IDLE && clk_en_i && irq_global_en_i && any_pend
       && vector_table_select_i)
      |=> addr_q == $past(boot_reset_addr_i) + ADDR_W'(IVM_TABLE_OFS)
          + ADDR_W'({src_q, 1'b0});
   endproperty
   a_moved: assert property (p_moved) // [RQ12]
      else $error("moved table address wrong");

   property p_prio;
      @(posedge clock_i) disable iff (!reset_n_i)
      (state_q == IVM_ST_IDLE && clk_en_i && irq_global_en_i
       && irq_pending_i[0])
      |=> (valid_q && src_q == IVM_SRC_EXT_IRQ_0);
   endproperty
   a_prio: assert property (p_prio) // [RQ17]
      else $error("lowest vector did not win");

   property p_wdclr;
      @(posedge clock_i) disable iff (!reset_n_i)
      (state_q == IVM_ST_OFFER && clk_en_i && core_take_i && !is_reset_q
       && src_q == IVM_SRC_WATCHDOG)
      |=> (wdf_clr_q && wde_clr_q == $past(watchdog_reset_mode_i)
           && !valid_q);
   endproperty
   a_wdclr: assert property (p_wdclr) // [RQ16]
      else $error("watchdog flag clear missing");

   c_reset_taken: cover property (@(posedge clock_i)
      valid_q && is_reset_q && core_take_i && clk_en_i);
   c_irq_taken: cover property (@(posedge clock_i)
      valid_q && !is_reset_q && core_take_i && clk_en_i);
   c_moved_table: cover property (@(posedge clock_i)
      valid_q && !is_reset_q && tsel_q);
   c_wdog_combined: cover property (@(posedge clock_i) wde_clr_q);

endmodule

// ==== bench/ivm_core_model.sv ====
`timescale 1ns/1ns
// stands in for the core fetch and the peripheral request lines
module ivm_core_model (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // bench control
   input wire logic [29:0] req_set_i,
   input wire logic [1:0] take_wait_i,
   // mapper side
   input wire logic vector_valid_i,
   input wire logic [29:0] irq_ack_i,
   output logic [29:0] irq_pending_o,
   output logic core_take_o
);
   logic [1:0] wait_q;
   logic [29:0] pend_q;

   // a request stays up until its ack, as a real peripheral flag does;
   // the ack masks it at once, else the mapper sees the taken source twice
   assign irq_pending_o = pend_q & ~irq_ack_i;

   // the take may lag the offer to mimic a core finishing an instruction
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend_q <= 30'h0;
         core_take_o <= 1'b0;
         wait_q <= 2'h0;
      end else begin
         pend_q <= (pend_q | req_set_i) & ~irq_ack_i;
         if (vector_valid_i && !core_take_o && wait_q == take_wait_i) begin
            core_take_o <= 1'b1;
            wait_q <= 2'h0;
         end else if (vector_valid_i && !core_take_o) begin
            core_take_o <= 1'b0;
            wait_q <= wait_q + 2'h1;
         end else begin
            core_take_o <= 1'b0;
         end
      end
   end
endmodule

// ==== bench/interrupt_vector_mapper_test.sv ====
`timescale 1ns/1ns
module interrupt_vector_mapper_test;
   import ivm_pkg::*;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic clk_en_i = 1'b1;
   logic fuse = 1'b1;
   logic tsel = 1'b0;
   logic wmode = 1'b0;
   logic gen = 1'b1;
   logic [1:0] twait = 2'h0;
   logic [15:0] boot = 16'h7c00;
   logic [29:0] req_set = 30'h0;
   logic [29:0] ack_seen = 30'h0;
   logic [29:0] pend, ack;
   logic take, valid, is_rst, fclr, eclr;
   logic [15:0] addr;
   logic [4:0] src;
   int err_total = 0;
   int total_checks = 0;
   int n_fclr = 0;
   int n_eclr = 0;

   ivm_vector_mapper dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
      .boot_reset_select_fuse_i(fuse), .vector_table_select_i(tsel),
      .boot_reset_addr_i(boot), .watchdog_reset_mode_i(wmode),
      .irq_pending_i(pend), .irq_global_en_i(gen), .core_take_i(take),
      .vector_valid_o(valid), .vector_is_reset_o(is_rst),
      .vector_addr_o(addr), .vector_src_o(src), .irq_ack_o(ack),
      .watchdog_irq_flag_clr_o(fclr), .watchdog_irq_enable_clr_o(eclr));

   ivm_core_model core (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .req_set_i(req_set),
      .take_wait_i(twait), .vector_valid_i(valid), .irq_ack_i(ack),
      .irq_pending_o(pend), .core_take_o(take));

   // 4 ns period
   initial begin
      forever #2 clock_i = ~clock_i;
   end

   // tally one-cycle side pulses, they are too short to poll
   always @(posedge clock_i) begin
      ack_seen <= ack_seen | ack;
      n_fclr <= n_fclr + fclr;
      n_eclr <= n_eclr + eclr;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // bounded wait for the offer line to reach a level
   task automatic wait_lvl(input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         #1;
         n++;
      end while (valid !== lvl && n < 40);
      check({15'h0, valid}, {15'h0, lvl});
   endtask

   task automatic pulse(input logic [29:0] bits);
      @(posedge clock_i);
      req_set <= bits;
      @(posedge clock_i);
      req_set <= 30'h0;
   endtask

   task automatic next_vec(input logic [15:0] exp);
      wait_lvl(1'b1);
      check(addr, exp);
      check({15'h0, is_rst}, 16'h0);
      wait_lvl(1'b0);
   endtask

   task automatic fire(input int k, input logic [15:0] exp);
      pulse(30'h1 << k);
      wait_lvl(1'b1);
      check({11'h0, src}, 16'(k));
      next_vec(exp);
   endtask

   // fuse and select are set as reset goes low, fuse is read on release
   task automatic do_reset(input logic f, input logic s,
                           input logic [15:0] exp);
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      fuse <= f;
      tsel <= s;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      wait_lvl(1'b1);
      check({15'h0, is_rst}, 16'h1);
      check(addr, exp);
      wait_lvl(1'b0);
   endtask

   task automatic t_table();
      do_reset(1'b1, 1'b0, 16'h0000);
      for (int k = 0; k < 15; k++) begin
         fire(k, 16'(2 * k + 2));
      end
      for (int k = 15; k < 30; k++) begin
         fire(k, 16'(2 * k + 2));
      end
      // the last ack is tallied one edge after its take
      @(posedge clock_i);
      #1;
      check(ack_seen[15:0], 16'hffff);
      check({2'h0, ack_seen[29:16]}, 16'h3fff);
      check(16'(n_fclr), 16'h1);
      check(16'(n_eclr), 16'h0);
      $display("test table done");
   endtask

   // three at once with a slow core: lowest vector first
   task automatic t_prio();
      @(posedge clock_i);
      wmode <= 1'b1;
      twait <= 2'h2;
      pulse(30'h20000088);
      next_vec(16'h0008);
      next_vec(16'h0010);
      next_vec(16'h003c);
      check(16'(n_fclr), 16'h2);
      check(16'(n_eclr), 16'h1);
      $display("test priority done");
   endtask

   task automatic t_select();
      do_reset(1'b0, 1'b1, boot);
      fire(0, boot + 16'h0002);
      fire(29, boot + 16'h003c);
      do_reset(1'b1, 1'b1, 16'h0000);
      fire(2, boot + 16'h0006);
      @(posedge clock_i);
      tsel <= 1'b0;
      fire(9, 16'h0014);
      $display("test select done");
   endtask

   // no offer while globally disabled or while the clock is gated
   task automatic t_gate();
      @(posedge clock_i);
      gen <= 1'b0;
      pulse(30'h10);
      repeat (6) @(posedge clock_i);
      #1;
      check({15'h0, valid}, 16'h0);
      @(posedge clock_i);
      clk_en_i <= 1'b0;
      gen <= 1'b1;
      repeat (5) @(posedge clock_i);
      #1;
      check({15'h0, valid}, 16'h0);
      @(posedge clock_i);
      clk_en_i <= 1'b1;
      next_vec(16'h000a);
      $display("test gate done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // whole run needs well under 2000 cycles
   initial begin
      #20000;
      err_total++;
      test_done();
   end

   initial begin
      t_table();
      t_prio();
      t_select();
      t_gate();
      test_done();
   end
endmodule
